// *** design/mss_defs.vh ***
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH
// APB byte offsets
`define MSS_OFF_CTRL      12'h000
`define MSS_OFF_STATUS    12'h004
`define MSS_OFF_FLAGS     12'h008
`define MSS_OFF_MASK      12'h00C
`define MSS_OFF_DONE      12'h010
// CTRL fields
`define MSS_CTRL_SWRST    0
`define MSS_CTRL_SWLP     1
`define MSS_CTRL_PERMIT   2
`define MSS_CTRL_FAULT    3
`define MSS_CTRL_RESET    32'h0000_0004
// FLAGS fields
`define MSS_FLG_CHG       0
// State codes
`define MSS_ST_RESETTING  3'h0
`define MSS_ST_RESET      3'h1
`define MSS_ST_MGMT_INIT  3'h2
`define MSS_ST_LOW_POWER  3'h3
`define MSS_ST_POWER_UP   3'h4
`define MSS_ST_READY      3'h5
`define MSS_ST_POWER_DN   3'h6
`define MSS_ST_FAULT      3'h7
// Path states
`define MSS_PS_DEACT      2'h0
`define MSS_PS_INIT       2'h1
`define MSS_PS_ACTIVE     2'h2
// Transient activity time and clock period, ns
`define MSS_ACT_NS        200
`define MSS_CLK_NS        20
`endif

// *** design/mss_path_seq.v ***
`timescale 1ns/1ns
`include "mss_defs.vh"
module mss_path_seq #(
  parameter STEP = 10
) (
  input  wire       clk_sys_i,
  input  wire       srst_i,
  input  wire       ce_i,
  input  wire       hold_i,
  input  wire       enable_i,
  output wire       deact_o,
  output wire [1:0] state_o
);
  reg [1:0] st_r;
  reg [7:0] cnt_r;
  // Last count of the init phase, sized so the compare is 8 bits wide
  localparam [31:0] STEP_W = STEP - 1;
  // Own state only, no coupling to sibling paths
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r  <= `MSS_PS_DEACT;
      cnt_r <= 8'h00;
    end else if (ce_i) begin
      case (st_r)
        `MSS_PS_DEACT: begin
          cnt_r <= 8'h00;
          if (enable_i && !hold_i) st_r <= `MSS_PS_INIT;
        end
        `MSS_PS_INIT: begin
          if (hold_i || !enable_i) begin
            st_r <= `MSS_PS_DEACT;
          end else if (cnt_r == STEP_W[7:0]) begin
            st_r <= `MSS_PS_ACTIVE;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        `MSS_PS_ACTIVE: begin
          if (hold_i || !enable_i) st_r <= `MSS_PS_DEACT;
        end
        default: st_r <= `MSS_PS_DEACT;
      endcase
    end
  end
  assign deact_o = (st_r == `MSS_PS_DEACT);
  assign state_o = st_r;
endmodule // mss_path_seq

// *** design/mss_sync2.v ***
`timescale 1ns/1ns
module mss_sync2 #(
  parameter W = 1
) (
  input  wire         clk_sys_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  // No reset: first stage feeds only the second
  always @(posedge clk_sys_i) begin
    if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule // mss_sync2

// *** design/mss_top.v ***
`timescale 1ns/1ns
`include "mss_defs.vh"
// What this block does
// - One module-wide sequencer governs management init and power mode.
// - One path sequencer is instantiated per provisioned application instance.
// - Path sequencers run concurrently and independently of each other.
// - Transient states finish their activity then advance unless preempted.
// - Sequencer starts right after power-up, for modules and cables alike.
// - Register map is not evaluated or kept before low power first reached.
// - Dynamic status may be invalid during transients; host must not trust it.
// - State changes leave latched flags untouched.
// - Interrupt stays asserted until host reads or masks every set flag.
// - State-change flag set only on entering fault, low power, ready.
// - No state-change flag when the entered state exits at once.
// - Power-up starts in reset, stays while reset condition holds.
// - Reset condition false in reset moves to management init.
// - Priority is reset condition, then fault condition, then the rest.
// - Reset condition is supply low, reset pin, or soft reset bit.
// - Low power request is sw bit, or permit and pin request; defaults 0,1.
// - Low power exit needs request and all paths deactivated.
module mss_top #(
  parameter NPATH = 2,
  parameter STEP  = (`MSS_ACT_NS + `MSS_CLK_NS - 1) / `MSS_CLK_NS
) (
  input  wire             clk_sys_i,
  input  wire             srst_i,
  input  wire             ce_i,
  input  wire             supply_low_reset_i,
  input  wire             host_reset_n_i,
  input  wire             pin_low_power_request_i,
  input  wire             fault_detect_i,
  input  wire [NPATH-1:0] path_enable_i,
  input  wire             psel_i,
  input  wire             penable_i,
  input  wire             pwrite_i,
  input  wire [11:0]      paddr_i,
  input  wire [31:0]      pwdata_i,
  output reg  [31:0]      prdata_o,
  output wire             pready_o,
  output wire             pslverr_o,
  output wire             int_n_o,
  output wire             map_valid_o,
  output wire             status_valid_o,
  output wire [2:0]       state_o
);
  reg  [2:0]       st_r;
  reg  [2:0]       st_nxt;
  reg  [7:0]       cnt_r;
  reg              map_live_r;
  reg              soft_rst_r;
  reg              sw_lp_r;
  reg              permit_r;
  reg              fault_en_r;
  reg              chg_flag_r;
  reg              chg_mask_r;
  reg              int_r;
  wire [2:0]       pins_s;
  wire [NPATH-1:0] deact_s;
  wire             reset_cond;
  wire             fault_cond;
  wire             lp_req_cond;
  wire             lp_exit_cond;
  wire             act_done;
  wire             wr_en;
  wire             rd_en;
  wire             set_chg;
  // Typed copies, so single bits can be selected
  localparam [31:0] STEP_W   = STEP - 1;
  localparam [31:0] CTRL_RST = `MSS_CTRL_RESET;

  // Pins pass two flops before use
  mss_sync2 #(
    .W (3)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .d_i       ({supply_low_reset_i, host_reset_n_i, pin_low_power_request_i}),
    .q_o       (pins_s)
  );

  // Hold paths down outside ready and power-up
  wire path_hold = (st_r != `MSS_ST_READY) && (st_r != `MSS_ST_POWER_UP);

  genvar g;
  generate
    for (g = 0; g < NPATH; g = g + 1) begin : g_path
      mss_path_seq #(
        .STEP (STEP)
      ) u_path (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .hold_i    (path_hold),
        .enable_i  (path_enable_i[g]),
        .deact_o   (deact_s[g]),
        .state_o   ()
      );
    end
  endgenerate

  assign reset_cond   = pins_s[2] | ~pins_s[1] | soft_rst_r;
  assign fault_cond   = fault_en_r & fault_detect_i;
  assign lp_req_cond  = sw_lp_r | (permit_r & pins_s[0]);
  assign lp_exit_cond = lp_req_cond & (&deact_s);
  assign act_done     = (cnt_r == STEP_W[7:0]);

  // Single sequencer, priority reset > fault > others
  always @* begin
    st_nxt = st_r;
    if (reset_cond) begin
      if (st_r != `MSS_ST_RESET) st_nxt = `MSS_ST_RESETTING;
      else st_nxt = `MSS_ST_RESET;
      if (st_r == `MSS_ST_RESETTING && act_done) st_nxt = `MSS_ST_RESET;
    end else if (fault_cond && st_r != `MSS_ST_RESET && st_r != `MSS_ST_RESETTING) begin
      st_nxt = `MSS_ST_FAULT;
    end else begin
      case (st_r)
        `MSS_ST_RESETTING: if (act_done) st_nxt = `MSS_ST_RESET;
        `MSS_ST_RESET:     st_nxt = `MSS_ST_MGMT_INIT;
        `MSS_ST_MGMT_INIT: if (act_done) st_nxt = `MSS_ST_LOW_POWER;
        `MSS_ST_LOW_POWER: if (!lp_req_cond) st_nxt = `MSS_ST_POWER_UP;
        `MSS_ST_POWER_UP: begin
          if (lp_req_cond) st_nxt = `MSS_ST_POWER_DN;
          else if (act_done) st_nxt = `MSS_ST_READY;
        end
        `MSS_ST_READY:     if (lp_exit_cond) st_nxt = `MSS_ST_POWER_DN;
        `MSS_ST_POWER_DN:  if (act_done) st_nxt = `MSS_ST_LOW_POWER;
        `MSS_ST_FAULT:     st_nxt = `MSS_ST_FAULT;
        default:           st_nxt = `MSS_ST_RESETTING;
      endcase
    end
  end

  // Registered state, one step per edge; srst models power-up
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r  <= `MSS_ST_RESET;
      cnt_r <= 8'h00;
    end else if (ce_i) begin
      st_r <= st_nxt;
      if (st_nxt != st_r || act_done) cnt_r <= 8'h00;
      else cnt_r <= cnt_r + 8'h01;
    end
  end

  // Flag only on settled entry of fault, low power, ready
  wire entered = (st_nxt != st_r);
  wire flag_state = (st_r == `MSS_ST_FAULT) || (st_r == `MSS_ST_READY) ||
                    (st_r == `MSS_ST_LOW_POWER);
  reg  just_in_r;
  always @(posedge clk_sys_i) begin
    if (srst_i) just_in_r <= 1'b0;
    else if (ce_i) just_in_r <= entered;
  end
  // Checked one cycle after entry, so a state left at once never flags
  assign set_chg = just_in_r && flag_state && !entered;

  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & penable_i & ~pwrite_i;

  // Map contents ignored until low power first reached
  always @(posedge clk_sys_i) begin
    if (srst_i) map_live_r <= 1'b0;
    else if (ce_i) begin
      if (st_r == `MSS_ST_RESET || st_r == `MSS_ST_RESETTING) map_live_r <= 1'b0;
      else if (st_r == `MSS_ST_LOW_POWER) map_live_r <= 1'b1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      soft_rst_r <= CTRL_RST[`MSS_CTRL_SWRST];
      sw_lp_r    <= CTRL_RST[`MSS_CTRL_SWLP];
      permit_r   <= CTRL_RST[`MSS_CTRL_PERMIT];
      fault_en_r <= CTRL_RST[`MSS_CTRL_FAULT];
      chg_mask_r <= 1'b0;
    end else if (ce_i) begin
      if (st_r == `MSS_ST_RESET) soft_rst_r <= 1'b0;   // Self-clearing
      if (wr_en && map_live_r && paddr_i == `MSS_OFF_CTRL) begin
        soft_rst_r <= pwdata_i[`MSS_CTRL_SWRST];
        sw_lp_r    <= pwdata_i[`MSS_CTRL_SWLP];
        permit_r   <= pwdata_i[`MSS_CTRL_PERMIT];
        fault_en_r <= pwdata_i[`MSS_CTRL_FAULT];
      end
      if (wr_en && map_live_r && paddr_i == `MSS_OFF_MASK) chg_mask_r <= pwdata_i[0];
    end
  end

  // Read clears flag; set wins over clear; state changes keep it
  wire rd_flags = rd_en && paddr_i == `MSS_OFF_FLAGS;
  always @(posedge clk_sys_i) begin
    if (srst_i) chg_flag_r <= 1'b0;
    else if (ce_i) begin
      if (set_chg) chg_flag_r <= 1'b1;
      else if (rd_flags) chg_flag_r <= 1'b0;
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) int_r <= 1'b0;
    else if (ce_i) int_r <= (chg_flag_r | set_chg) & ~chg_mask_r & ~rd_flags | set_chg & ~chg_mask_r;
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) prdata_o <= 32'h0000_0000;
    else if (ce_i && psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        `MSS_OFF_CTRL:   prdata_o <= {28'h0000000, fault_en_r, permit_r, sw_lp_r, soft_rst_r};
        `MSS_OFF_STATUS: prdata_o <= {29'h00000000, st_r};
        `MSS_OFF_FLAGS:  prdata_o <= {31'h00000000, chg_flag_r};
        `MSS_OFF_MASK:   prdata_o <= {31'h00000000, chg_mask_r};
        `MSS_OFF_DONE:   prdata_o <= {{(32-NPATH){1'b0}}, deact_s};
        default:         prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & (paddr_i > `MSS_OFF_DONE);
  assign int_n_o   = ~int_r;
  assign map_valid_o = map_live_r;
  // Dynamic status untrusted in transient states
  assign status_valid_o = (st_r == `MSS_ST_LOW_POWER) || (st_r == `MSS_ST_READY) ||
                          (st_r == `MSS_ST_FAULT);
  assign state_o = st_r;
endmodule // mss_top

// *** verif/module_state_sequencer_tb_top.sv ***
`timescale 1ns/1ns
`include "mss_defs.vh"
module module_state_sequencer_tb_top;
  logic        clk_sys_i = 1'h0;
  logic        srst_i = 1'h1;
  logic        fault_detect_i = 1'h0;
  logic [1:0]  path_enable_i = 2'h0;
  logic        psel_i = 1'h0;
  logic        penable_i = 1'h0;
  logic        pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] rd;
  logic        err;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, int_n_o, map_valid_o, status_valid_o;
  wire  [2:0]  state_o;
  wire         host_reset_n, lp_req, supply_low;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  mss_host_model i_host (.clk_sys_i(clk_sys_i), .host_reset_n_o(host_reset_n),
    .pin_lp_req_o(lp_req), .supply_low_o(supply_low));
  // Short transient count keeps the run brief
  mss_top #(.NPATH(2), .STEP(2)) i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'h1),
    .supply_low_reset_i(supply_low), .host_reset_n_i(host_reset_n),
    .pin_low_power_request_i(lp_req), .fault_detect_i(fault_detect_i),
    .path_enable_i(path_enable_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .int_n_o(int_n_o),
    .map_valid_o(map_valid_o), .status_valid_o(status_valid_o), .state_o(state_o));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task wst(input logic [2:0] s);
    int n;
    n = 0;
    // Look between edges, where the state register has settled
    @(negedge clk_sys_i);
    while (state_o !== s && n < 300) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk({29'h0, state_o}, {29'h0, s});
  endtask

  task t_boot;
    wst(`MSS_ST_LOW_POWER);
    @(negedge clk_sys_i);
    chk({31'h0, map_valid_o}, 32'h1);
    apb(1'h1, `MSS_OFF_MASK, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, int_n_o}, 32'h0);
    apb(1'h0, `MSS_OFF_FLAGS, 32'h0);
    chk(rd, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, int_n_o}, 32'h1);
  endtask

  task t_up;
    i_host.drive(1'h1, 1'h0, 1'h0);
    wst(`MSS_ST_POWER_UP);
    chk({31'h0, status_valid_o}, 32'h0);
    wst(`MSS_ST_READY);
    apb(1'h0, `MSS_OFF_FLAGS, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, `MSS_OFF_STATUS, 32'h0);
    chk(rd, {29'h0, `MSS_ST_READY});
  endtask

  task t_paths;
    path_enable_i <= 2'h3;
    apb(1'h1, `MSS_OFF_CTRL, 32'h6);
    repeat (20) @(posedge clk_sys_i);
    chk({29'h0, state_o}, {29'h0, `MSS_ST_READY});
    path_enable_i <= 2'h1;
    repeat (20) @(posedge clk_sys_i);
    apb(1'h0, `MSS_OFF_DONE, 32'h0);
    chk(rd, 32'h2);
    path_enable_i <= 2'h0;
    wst(`MSS_ST_LOW_POWER);
    apb(1'h0, `MSS_OFF_FLAGS, 32'h0);
    chk(rd, 32'h1);
    i_host.drive(1'h1, 1'h1, 1'h0);
    apb(1'h1, `MSS_OFF_CTRL, 32'h0);
    wst(`MSS_ST_READY);
    apb(1'h1, `MSS_OFF_CTRL, 32'h4);
    wst(`MSS_ST_LOW_POWER);
  endtask

  task t_fault;
    apb(1'h1, `MSS_OFF_CTRL, 32'hC);
    fault_detect_i <= 1'h1;
    wst(`MSS_ST_FAULT);
    i_host.drive(1'h0, 1'h1, 1'h0);
    wst(`MSS_ST_RESETTING);
    wst(`MSS_ST_RESET);
    repeat (10) @(posedge clk_sys_i);
    chk({29'h0, state_o}, {29'h0, `MSS_ST_RESET});
    fault_detect_i <= 1'h0;
    i_host.drive(1'h1, 1'h1, 1'h0);
    wst(`MSS_ST_LOW_POWER);
  endtask

  task t_srcs;
    for (int i = 0; i < 2; i++) begin
      if (i == 0)
        i_host.drive(1'h1, 1'h1, 1'h1);
      else
        apb(1'h1, `MSS_OFF_CTRL, 32'h5);
      wst(`MSS_ST_RESET);
      i_host.drive(1'h1, 1'h1, 1'h0);
      wst(`MSS_ST_LOW_POWER);
    end
    i_host.drive(1'h1, 1'h0, 1'h0);
    wst(`MSS_ST_READY);
    apb(1'h0, `MSS_OFF_FLAGS, 32'h0);
    apb(1'h1, `MSS_OFF_CTRL, 32'h5);
    wst(`MSS_ST_RESET);
    // Low power is left at once here, so no interrupt may follow it
    wst(`MSS_ST_POWER_UP);
    @(negedge clk_sys_i);
    chk({31'h0, int_n_o}, 32'h1);
    wst(`MSS_ST_READY);
    apb(1'h0, `MSS_OFF_FLAGS, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, 12'h014, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'h0;
    t_boot;
    t_up;
    t_paths;
    t_fault;
    t_srcs;
    stop_test;
  end

  // Whole sequence needs a few hundred cycles, well under the 20000-cycle limit
  initial begin
    #400000;
    n_mismatch++;
    stop_test;
  end
endmodule // module_state_sequencer_tb_top

// *** verif/mss_host_model.sv ***
`timescale 1ns/1ns
module mss_host_model (
  input  wire  clk_sys_i,
  output logic host_reset_n_o,
  output logic pin_lp_req_o,
  output logic supply_low_o
);
  // Request held at power-up to pause in low power
  initial begin
    host_reset_n_o = 1'h1;
    pin_lp_req_o = 1'h1;
    supply_low_o = 1'h0;
  end
  // Pins move just after an edge, as a real controller's outputs do
  task drive(input logic rst_n, input logic lp, input logic sl);
    @(posedge clk_sys_i);
    host_reset_n_o <= rst_n;
    pin_lp_req_o <= lp;
    supply_low_o <= sl;
  endtask
endmodule // mss_host_model

// *** verif/mss_top_props.sv ***
`timescale 1ns/1ns
module mss_top_props (
  input wire        clk_sys_i,
  input wire        srst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire        int_n_o,
  input wire        map_valid_o,
  input wire        status_valid_o,
  input wire [2:0]  state_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // Resetting, mgmt init, power up, power down
  wire in_trans = state_o inside {3'h0, 3'h2, 3'h4, 3'h6};

  chk_srst_state: assert property (disable iff (1'h0)
    srst_i |=> state_o == 3'h1 && int_n_o && !map_valid_o) else $error("bad reset state");
  chk_reset_exit: assert property (
    state_o == 3'h1 ##1 state_o != 3'h1 |-> state_o == 3'h2) else $error("bad reset exit");
  chk_fault_exit: assert property (
    state_o == 3'h7 ##1 state_o != 3'h7 |-> state_o == 3'h0) else $error("bad fault exit");
  chk_trans_end: assert property (
    in_trans |-> ##[1:40] !in_trans) else $error("transient state stuck");
  chk_status_trans: assert property (
    in_trans |-> !status_valid_o) else $error("status valid in transient");
  chk_map_first: assert property (
    $rose(map_valid_o) |-> state_o == 3'h3 || $past(state_o) == 3'h3
      || $past(state_o, 2) == 3'h3) else $error("map valid too early");
  // Low power left at once must stay silent
  chk_lp_silent: assert property (
    int_n_o && state_o == 3'h3 && $past(state_o) == 3'h2 ##1 state_o == 3'h4
      |-> int_n_o [*3]) else $error("flag on skipped state");
  chk_status_read: assert property (
    psel_i && !penable_i && !pwrite_i && paddr_i == 12'h004 ##1 penable_i
      |-> prdata_o[2:0] == $past(state_o)) else $error("status read wrong");

  cov_fault: cover property (state_o == 3'h7);
  cov_irq: cover property ($fell(int_n_o));
  cov_skip_lp: cover property (state_o == 3'h3 ##1 state_o == 3'h4);
endmodule // mss_top_props

bind mss_top mss_top_props i_props (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .int_n_o(int_n_o),
  .map_valid_o(map_valid_o), .status_valid_o(status_valid_o), .state_o(state_o));
